// ### inc/burst_write_pkg.sv
// package for the serial burst write handoff block
// assumes a byte-wide serial port with 24-bit command data words
package burst_write_pkg;
	localparam logic [7:0] OPC_WRITE       = 8'h02;
	localparam logic [7:0] OPC_READ        = 8'h03;
	localparam logic [7:0] ADDR_WORD_A_HI  = 8'h06;
	localparam logic [7:0] ADDR_CTRL_MID   = 8'h01;
	localparam int         MAX_DATA_BYTES  = 6;
	localparam int         REQ_BIT_CTRL    = 8;
	localparam int         REQ_BIT_MID     = 0;
	localparam logic [23:0] WORD_RESET     = 24'h000000;
	localparam int         CLK_PERIOD_NS   = 50;
	localparam int         POLL_DELAY_US   = 1000;
	localparam int         POLL_DELAY_CYC  = POLL_DELAY_US * 1000 / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ST_OPCODE = 2'b00,
		ST_ADDR   = 2'b01,
		ST_DATA   = 2'b11,
		ST_IGNORE = 2'b10
	} port_state_e;
endpackage

// ### tb/mcu_master.sv
// serial master model for the burst write port
// assumes mode 0, 64 ns serial clock standing low between frames
`timescale 1ns/1ns
`default_nettype none
module mcu_master (
	// serial link
	output logic      sclk_o,
	output logic      sel_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		sel_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// one byte; data line flips after the last bit
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = b[i];
			#32 sclk_o = 1'b1;
			r[i] = miso_i;
			#32 sclk_o = 1'b0;
		end
		mosi_o = ~b[0];
	endtask
	// n bytes go out from the top of q
	task automatic frame(input logic [79:0] q, input int n, output logic [7:0] r);
		sel_n_o = 1'b0;
		#40;
		for (int k = 0; k < n; k++) begin
			xfer(q[79 - 8*k -: 8], r);
		end
		#40 sel_n_o = 1'b1;
		#300;
	endtask
endmodule
`default_nettype wire

// ### tb/serial_burst_write_handoff_tb.sv
// bench for the burst write handoff block
// assumes the master model drives the link; bench plays the engine
`timescale 1ns/1ns
`default_nettype none
module serial_burst_write_handoff_tb;
	import burst_write_pkg::*;
	logic        clk_i, reset_i, take;
	wire logic   sclk, sel_n, mosi, miso, req, oe;
	wire logic [23:0] wa, wb;
	logic [7:0]  r;
	int          n_fail = 0;
	int          n_compared = 0;
	mcu_master mcu (.sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi), .miso_i(miso));
	serial_burst_write_handoff dut (.clk_i(clk_i), .reset_i(reset_i),
		.config_serial_clock_i(sclk), .port_select_n_i(sel_n), .mosi_i(mosi),
		.miso_o(miso), .miso_oe_o(oe), .engine_take_i(take),
		.engine_transfer_request_o(req), .command_data_word_a_o(wa),
		.command_data_word_b_o(wb));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic poll(input logic exp);
		mcu.frame({OPC_READ, ADDR_CTRL_MID, 8'h00, 56'h0}, 3, r);
		check({16'h0, r}, {23'h0, exp});
	endtask
	// waits for the request, then hands the words to the engine
	task automatic take_words;
		for (int i = 0; i < 20 && req !== 1'b1; i++)
			@(posedge clk_i);
		if (req !== 1'b1) begin
			n_fail++;
			$display("MISMATCH %0t: request never rose", $time);
			wrap_up();
		end
		poll(1'b1);
		@(posedge clk_i) take <= 1'b1;
		@(posedge clk_i) take <= 1'b0;
		repeat (2) @(posedge clk_i);
		check(req, 1'b0);
		check(oe, 1'b0);
		poll(1'b0);
	endtask
	task automatic burst_six;
		mcu.frame({OPC_WRITE, ADDR_WORD_A_HI, 48'h123456789abc, 16'h0000}, 8, r);
		check(req, 1'b1);
		check(wa, 24'h123456);
		check(wb, 24'h789abc);
		take_words();
		$display("burst_six done");
	endtask
	task automatic burst_long;
		// over-long burst: bytes seven and eight must be dropped
		mcu.frame({OPC_WRITE, ADDR_WORD_A_HI, 64'hfedcba9876540ff0}, 10, r);
		check(wa, 24'hfedcba);
		check(wb, 24'h987654);
		take_words();
		$display("burst_long done");
	endtask
	task automatic burst_short;
		mcu.frame({OPC_WRITE, ADDR_WORD_A_HI, 24'ha55ac3, 40'h0}, 5, r);
		check(wa, 24'ha55ac3);
		check(wb, 24'h987654);
		take_words();
		$display("burst_short done");
	endtask
	initial begin
		reset_i = 1'b1;
		take = 1'b0;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		check(wa, WORD_RESET);
		check(wb, WORD_RESET);
		check(req, 1'b0);
		burst_six();
		burst_long();
		burst_short();
		wrap_up();
	end
endmodule
`default_nettype wire

// ### verilog/serial_burst_write_handoff.sv
// serial burst write port feeding command data words to the engine
// assumes spi mode 0 from an external master; engine on clk_i domain
// How it works
// - data bytes fill word a then word b, in order.
// - select rising ends the burst and sets the transfer request.
// - engine uses words a and b for the current command.
// - engine clears the request once it has taken the data.
// - request is control bit 8, read as bit 0 of middle byte 01.
`timescale 1ns/1ns
`default_nettype none
module serial_burst_write_handoff
	import burst_write_pkg::*;
(
	// system
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	// serial link
	input  wire logic        config_serial_clock_i,
	input  wire logic        port_select_n_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	output logic             miso_oe_o,
	// engine side
	input  wire logic        engine_take_i,
	output logic             engine_transfer_request_o,
	output logic [23:0]      command_data_word_a_o,
	output logic [23:0]      command_data_word_b_o
);
	// link domain: shift logic, reset by select high
	port_state_e state_q, state_d;
	logic [2:0]  bit_q, bit_d;
	logic [6:0]  shift_q, shift_d;
	logic [2:0]  byte_q, byte_d;
	logic [47:0] data_q, data_d;
	logic        rd_q, rd_d;
	logic [7:0]  out_q, out_d;
	logic        hit_q, hit_d;
	logic        burst_l_q, burst_l_d;
	logic        req_l1_q, req_l2_q;
	logic [7:0]  rx_byte;

	always_comb begin
		rx_byte = {shift_q, mosi_i};
		state_d = state_q;
		bit_d   = bit_q + 3'd1;
		shift_d = rx_byte[6:0];
		byte_d  = byte_q;
		data_d  = data_q;
		rd_d    = rd_q;
		hit_d   = 1'b0;
		if (bit_q == 3'd7) begin
			unique case (state_q)
				ST_OPCODE: begin
					if (rx_byte == OPC_WRITE) begin
						state_d = ST_ADDR;
					end else if (rx_byte == OPC_READ) begin
						state_d = ST_ADDR;
						rd_d    = 1'b1;
					end else begin
						state_d = ST_IGNORE;
					end
				end
				ST_ADDR: begin
					if (!rd_q && rx_byte == ADDR_WORD_A_HI) begin
						state_d = ST_DATA;
					end else begin
						state_d = ST_IGNORE;
					end
					// poll of the middle control byte loads the reply next fall
					if (rd_q && rx_byte == ADDR_CTRL_MID) begin
						hit_d = 1'b1;
					end
				end
				ST_DATA: begin
					if (int'(byte_q) < MAX_DATA_BYTES) begin
						data_d[47 - 8*byte_q -: 8] = rx_byte;
						byte_d = byte_q + 3'd1;
					end
				end
				ST_IGNORE: begin
				end
			endcase
		end
		// request only follows a frame that reached the data phase
		burst_l_d = (state_d == ST_DATA);
	end

	always_ff @(posedge config_serial_clock_i or posedge port_select_n_i) begin
		if (port_select_n_i) begin
			state_q <= ST_OPCODE;
			bit_q   <= 3'd0;
			shift_q <= 7'h00;
			byte_q  <= 3'd0;
			rd_q    <= 1'b0;
			hit_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q   <= bit_d;
			shift_q <= shift_d;
			byte_q  <= byte_d;
			rd_q    <= rd_d;
			hit_q   <= hit_d;
		end
	end

	// byte buffer holds its value after select rises, read by clk_i later
	// no reset on purpose: both must outlast select high
	always_ff @(posedge config_serial_clock_i) begin
		data_q    <= data_d;
		burst_l_q <= burst_l_d;
	end

	// request level carried into link domain for the poll read
	always_ff @(posedge config_serial_clock_i) begin
		req_l1_q <= engine_transfer_request_o;
		req_l2_q <= req_l1_q;
	end

	// poll read: middle control byte returns request on bit 0
	// loaded on the fall after the address byte, so bit 7 leads the next rise
	always_comb begin
		out_d = {out_q[6:0], 1'b0};
		if (hit_q) begin
			out_d = 8'h00;
			out_d[REQ_BIT_MID] = req_l2_q;
		end
	end

	always_ff @(negedge config_serial_clock_i or posedge port_select_n_i) begin
		if (port_select_n_i) begin
			out_q <= 8'h00;
		end else begin
			out_q <= out_d;
		end
	end

	assign miso_o    = out_q[7];
	assign miso_oe_o = ~port_select_n_i;

	// system domain: select synchroniser and word capture
	logic sel_s1_q, sel_s2_q, sel_s3_q;
	logic req_q, req_d;
	logic [47:0] cap_q, cap_d;
	logic [1:0]  ws_q;
	logic        sel_rise;
	logic        burst_done;

	// burst flag crosses on two flops; it settles long before select rises
	// so the synced rise of select qualified by it marks a finished burst
	assign sel_rise   = sel_s2_q & ~sel_s3_q;
	assign burst_done = sel_rise & ws_q[1];

	always_comb begin
		req_d   = req_q;
		cap_d   = cap_q;
		if (burst_done) begin
			req_d = 1'b1;
			cap_d = data_q;
		end else if (engine_take_i) begin
			req_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sel_s3_q <= 1'b1;
			req_q    <= 1'b0;
			ws_q     <= 2'b00;
			cap_q    <= {WORD_RESET, WORD_RESET};
		end else begin
			sel_s1_q <= port_select_n_i;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
			req_q    <= req_d;
			ws_q     <= {ws_q[0], burst_l_q};
			cap_q    <= cap_d;
		end
	end

	assign engine_transfer_request_o = req_q;
	assign command_data_word_a_o     = cap_q[47:24];
	assign command_data_word_b_o     = cap_q[23:0];

	// request set and clear, in the clk_i domain
	sequence burst_closes;
		sel_rise && ws_q[1];
	endsequence
	sequence engine_takes;
		req_q && engine_take_i && !sel_rise;
	endsequence

	chk_req_set: assert property (@(posedge clk_i) disable iff (reset_i)
		burst_closes |=> req_q)
		else $error("request not set after burst");
	chk_req_clear: assert property (@(posedge clk_i) disable iff (reset_i)
		engine_takes |=> !req_q)
		else $error("request not cleared");
	chk_req_stand: assert property (@(posedge clk_i) disable iff (reset_i)
		req_q && !engine_take_i |=> req_q)
		else $error("request dropped before the engine took it");
	chk_req_cause: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(req_q) |-> $past(burst_done))
		else $error("request rose without a burst end");
	chk_word_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		!sel_rise |=> $stable(cap_q))
		else $error("words changed outside a burst end");
	chk_byte_cap: assert property (@(posedge config_serial_clock_i) disable iff (port_select_n_i)
		int'(byte_q) <= MAX_DATA_BYTES)
		else $error("byte count past six");
	// link domain: poll reply carries the request in bit 0
	chk_poll_load: assert property (@(negedge config_serial_clock_i) disable iff (port_select_n_i)
		hit_q |=> out_q == {7'h00, $past(req_l2_q)})
		else $error("poll reply not loaded with the request");
endmodule
`default_nettype wire
